// [logic/serial_memory_read_commands.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------------
// byte fifo between array fetch and lane shifter
// ------------------------------------------------------------------
module srmr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  // pointers need a power of two depth
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("srmr_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];    // storage words
  logic [PW:0] wrPtr_q;             // write pointer with wrap bit
  logic [PW:0] rdPtr_q;             // read pointer with wrap bit
  wire logic push = inValid & inReady;
  wire logic pop = outValid & outReady;
  wire logic full = (wrPtr_q[PW] != rdPtr_q[PW]) && (wrPtr_q[PW-1:0] == rdPtr_q[PW-1:0]);

  assign inReady = ~full;
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData = mem[rdPtr_q[PW-1:0]];

  // pointer update, flush empties at once
  always_ff @(posedge ref_clk) begin
    if (reset || flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end

  // storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_q[PW-1:0]] <= inData;
    end
  end
endmodule

// ------------------------------------------------------------------
// read command interpreter
// ------------------------------------------------------------------
module serial_memory_read_commands #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic chipSelectN,
  input wire logic serialClock,
  input wire logic [3:0] ioIn,
  output srmr_pkg::srmr_pad_t ioDrive,
  input wire logic dualLaneProtocol,
  input wire logic quadLaneProtocol,
  input wire logic [3:0] latencyCode,
  output logic memReadValid,
  input wire logic memReadReady,
  output logic [srmr_pkg::ADDR_BITS-1:0] memReadAddr,
  input wire logic [7:0] memReadData,
  output logic continuousMode
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // bits moved per edge for a lane code
  function automatic logic [4:0] laneCount(input logic [1:0] code);
    laneCount = (code == srmr_pkg::LANES_FOUR) ? 5'h04 : (code == srmr_pkg::LANES_TWO) ? 5'h02 : 5'h01;
  endfunction

  // shift received lanes in, msb first
  function automatic logic [23:0] shiftIn(input logic [23:0] sh, input logic [3:0] io, input logic [1:0] code);
    case (code)
      srmr_pkg::LANES_FOUR: shiftIn = {sh[19:0], io};
      srmr_pkg::LANES_TWO: shiftIn = {sh[21:0], io[1:0]};
      default: shiftIn = {sh[22:0], io[0]};
    endcase
  endfunction

  // top bits of a byte onto the pads, highest lane first
  function automatic srmr_pkg::srmr_pad_t laneOut(input logic [7:0] b, input logic [1:0] code);
    case (code)
      srmr_pkg::LANES_FOUR: laneOut = {b[7:4], 4'hF};
      srmr_pkg::LANES_TWO: laneOut = {2'h0, b[7:6], 4'h3};
      default: laneOut = {2'h0, b[7], 1'b0, 4'h2};
    endcase
  endfunction

  // command shape per opcode and protocol
  function automatic srmr_pkg::srmr_cmd_t decodeCmd(input logic [7:0] op, input logic dual, input logic quad);
    logic [1:0] pw;
    logic single;
    pw = quad ? srmr_pkg::LANES_FOUR : dual ? srmr_pkg::LANES_TWO : srmr_pkg::LANES_ONE;
    single = ~dual & ~quad;
    case (op)
      srmr_pkg::CMD_PLAIN_READ: decodeCmd = {1'b1, pw, pw, 1'b0, 1'b0};
      srmr_pkg::CMD_FAST_READ: decodeCmd = {1'b1, pw, pw, 1'b0, 1'b1};
      srmr_pkg::CMD_DOUBLE_RATE_LATENCY_READ:
        decodeCmd = {quad, srmr_pkg::LANES_FOUR, srmr_pkg::LANES_FOUR, 1'b1, 1'b1};
      srmr_pkg::CMD_TWO_LANE_DATA_READ:
        decodeCmd = {single, srmr_pkg::LANES_ONE, srmr_pkg::LANES_TWO, 1'b0, 1'b1};
      srmr_pkg::CMD_TWO_LANE_ADDR_DATA_READ:
        decodeCmd = {single, srmr_pkg::LANES_TWO, srmr_pkg::LANES_TWO, 1'b0, 1'b1};
      srmr_pkg::CMD_FOUR_LANE_DATA_READ:
        decodeCmd = {single, srmr_pkg::LANES_ONE, srmr_pkg::LANES_FOUR, 1'b0, 1'b1};
      srmr_pkg::CMD_FOUR_LANE_ADDR_DATA_READ:
        decodeCmd = {~dual, srmr_pkg::LANES_FOUR, srmr_pkg::LANES_FOUR, 1'b0, 1'b1};
      srmr_pkg::CMD_DOUBLE_RATE_FOUR_LANE_READ:
        decodeCmd = {~dual, srmr_pkg::LANES_FOUR, srmr_pkg::LANES_FOUR, quad, 1'b1};
      default: decodeCmd = '0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and clock edges
  // ----------------------------------------------------------------
  logic [5:0] syncA_q;      // first stage, read only by second
  logic [5:0] syncB_q;      // second stage
  logic sckPrev_q;          // last sampled link clock
  wire logic csnS = syncB_q[5];
  wire logic sckS = syncB_q[4];
  wire logic [3:0] ioS = syncB_q[3:0];
  wire logic sckRise = sckS & ~sckPrev_q;
  wire logic sckFall = ~sckS & sckPrev_q;

  // two-flop capture of select, clock and lanes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      syncA_q <= srmr_pkg::SYNC_RESET;
      syncB_q <= srmr_pkg::SYNC_RESET;
      sckPrev_q <= 1'b0;
    end else begin
      syncA_q <= {chipSelectN, serialClock, ioIn};
      syncB_q <= syncA_q;
      sckPrev_q <= sckS;
    end
  end

  // ----------------------------------------------------------------
  // receive side decode
  // ----------------------------------------------------------------
  srmr_pkg::srmr_state_t state_q;     // frame phase
  srmr_pkg::srmr_state_t stateD;      // next phase
  srmr_pkg::srmr_cmd_t cmd_q;         // active command shape
  logic [23:0] rxSh_q;                // incoming bits
  logic [4:0] bitCnt_q;               // bits taken in this field
  logic [3:0] latCnt_q;               // dummy cycles counted
  logic contMode_q;                   // opcode-less next frame

  wire logic inOpcode = state_q == srmr_pkg::ST_OPCODE;
  wire logic inAddr = state_q == srmr_pkg::ST_ADDR;
  wire logic inMode = state_q == srmr_pkg::ST_MODE;
  wire logic [1:0] protoLanes = quadLaneProtocol ? srmr_pkg::LANES_FOUR :
                                dualLaneProtocol ? srmr_pkg::LANES_TWO : srmr_pkg::LANES_ONE;
  wire logic [1:0] rxLanes = inOpcode ? protoLanes : cmd_q.addrLanes;
  // double rate fields use both edges, but the first address bit waits for a rise
  wire logic captureEdge = (inOpcode & sckRise) |
                           (inAddr & (sckRise | (cmd_q.ddr & sckFall & (bitCnt_q != 5'h00)))) |
                           (inMode & (sckRise | (cmd_q.ddr & sckFall)));
  wire logic [23:0] rxShNext = shiftIn(rxSh_q, ioS, rxLanes);
  wire logic [4:0] rxCntNext = bitCnt_q + laneCount(rxLanes);
  wire logic opcodeDone = inOpcode & captureEdge & (rxCntNext == srmr_pkg::OPCODE_BITS);
  wire logic addrDone = inAddr & captureEdge & (rxCntNext == srmr_pkg::ADDR_FIELD_BITS);
  wire logic modeDone = inMode & captureEdge & (rxCntNext == srmr_pkg::MODE_BITS);
  wire srmr_pkg::srmr_cmd_t decoded = decodeCmd(rxShNext[7:0], dualLaneProtocol, quadLaneProtocol);
  wire logic latDone = (state_q == srmr_pkg::ST_LATENCY) & sckRise & ((latCnt_q + 4'h1) == latencyCode);
  wire srmr_pkg::srmr_state_t afterHeader = (latencyCode == 4'h0) ? srmr_pkg::ST_DATA : srmr_pkg::ST_LATENCY;
  // keep pattern depends on transfer rate
  wire logic modeKeeps = cmd_q.ddr ? (rxShNext[7:0] == srmr_pkg::CONT_DDR_BYTE) :
                                     (rxShNext[7:4] == srmr_pkg::CONT_NIBBLE);

  // frame sequencing
  always_comb begin
    stateD = state_q;
    if (csnS) begin
      stateD = srmr_pkg::ST_IDLE;
    end else begin
      case (state_q)
        srmr_pkg::ST_IDLE: stateD = contMode_q ? srmr_pkg::ST_ADDR : srmr_pkg::ST_OPCODE;
        srmr_pkg::ST_OPCODE: if (opcodeDone) stateD = decoded.legal ? srmr_pkg::ST_ADDR : srmr_pkg::ST_IGNORE;
        srmr_pkg::ST_ADDR: begin
          if (addrDone) begin
            stateD = cmd_q.hasMode ? srmr_pkg::ST_MODE : afterHeader;
          end
        end
        srmr_pkg::ST_MODE: if (modeDone) stateD = afterHeader;
        srmr_pkg::ST_LATENCY: if (latDone) stateD = srmr_pkg::ST_DATA;
        default: stateD = state_q;                                                  // data and ignore hold
      endcase
    end
  end

  // phase and field counters
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= srmr_pkg::ST_IDLE;
      bitCnt_q <= 5'h00;
      latCnt_q <= 4'h0;
    end else begin
      state_q <= stateD;
      bitCnt_q <= (stateD != state_q) ? 5'h00 : captureEdge ? rxCntNext : bitCnt_q;
      latCnt_q <= (state_q != srmr_pkg::ST_LATENCY) ? 4'h0 : sckRise ? latCnt_q + 4'h1 : latCnt_q;
    end
  end

  // incoming shift register, command and continuous flag
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rxSh_q <= 24'h000000;
      cmd_q <= '0;
      contMode_q <= srmr_pkg::CONT_RESET;
    end else begin
      if (captureEdge) begin
        rxSh_q <= rxShNext;
      end
      if (opcodeDone) begin
        cmd_q <= decoded;
      end
      if (modeDone) begin
        contMode_q <= modeKeeps;
      end
    end
  end

  // ----------------------------------------------------------------
  // array fetch into the fifo
  // ----------------------------------------------------------------
  logic fetchOn_q;                              // prefetch running
  logic [srmr_pkg::ADDR_BITS-1:0] fetchAddr_q;  // next byte to fetch
  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  wire logic memFire = memReadValid & memReadReady;

  assign memReadValid = fetchOn_q & fifoInReady & ~csnS;
  assign memReadAddr = fetchAddr_q;

  // start at the received address, step after each byte
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fetchOn_q <= 1'b0;
      fetchAddr_q <= '0;
    end else if (csnS) begin
      fetchOn_q <= 1'b0;
    end else if (addrDone) begin
      fetchOn_q <= 1'b1;
      fetchAddr_q <= rxShNext[srmr_pkg::ADDR_BITS-1:0];
    end else if (memFire) begin
      fetchAddr_q <= fetchAddr_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // data shifter onto the lanes
  // ----------------------------------------------------------------
  logic [7:0] txSh_q;          // remaining bits of current byte
  logic [3:0] txLeft_q;        // bits still to send
  srmr_pkg::srmr_pad_t pad_q;  // registered pad drive
  wire logic launchEdge = (state_q == srmr_pkg::ST_DATA) & (sckFall | (cmd_q.ddr & sckRise));
  wire logic txEmpty = txLeft_q == 4'h0;
  wire logic [7:0] txSrc = txEmpty ? fifoOutData : txSh_q;
  wire logic [4:0] txN = laneCount(cmd_q.dataLanes);
  wire logic fifoPop = launchEdge & txEmpty & fifoOutValid;

  assign ioDrive = pad_q;
  assign continuousMode = contMode_q;

  // one lane group per launch edge
  always_ff @(posedge ref_clk) begin
    if (reset || csnS) begin
      txSh_q <= 8'h00;
      txLeft_q <= 4'h0;
      pad_q <= '0;
    end else if (launchEdge) begin
      pad_q <= laneOut(txSrc, cmd_q.dataLanes);
      txSh_q <= txSrc << txN;
      txLeft_q <= (txEmpty ? 4'h8 : txLeft_q) - txN[3:0];
    end
  end

  srmr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .flush(csnS),
    .inValid(memFire),          // only bytes the array has accepted
    .inReady(fifoInReady),
    .inData(memReadData),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );

endmodule

// [logic/srmr_pkg.sv]
package srmr_pkg;

  // ----------------------------------------------------------------
  // read opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_PLAIN_READ = 8'h03;
  localparam logic [7:0] CMD_FAST_READ = 8'h0B;
  localparam logic [7:0] CMD_DOUBLE_RATE_LATENCY_READ = 8'h0D;
  localparam logic [7:0] CMD_TWO_LANE_DATA_READ = 8'h3B;
  localparam logic [7:0] CMD_TWO_LANE_ADDR_DATA_READ = 8'hBB;
  localparam logic [7:0] CMD_FOUR_LANE_DATA_READ = 8'h6B;
  localparam logic [7:0] CMD_FOUR_LANE_ADDR_DATA_READ = 8'hEB;
  localparam logic [7:0] CMD_DOUBLE_RATE_FOUR_LANE_READ = 8'hED;

  // ----------------------------------------------------------------
  // field sizes and patterns
  // ----------------------------------------------------------------
  localparam int ADDR_BITS = 19;                      // byte address width
  localparam logic [4:0] OPCODE_BITS = 5'h08;         // opcode length
  localparam logic [4:0] ADDR_FIELD_BITS = 5'h18;     // three address bytes
  localparam logic [4:0] MODE_BITS = 5'h08;           // mode byte length
  localparam logic [3:0] CONT_NIBBLE = 4'hA;          // single-rate keep pattern
  localparam logic [7:0] CONT_DDR_BYTE = 8'hA5;       // double-rate keep pattern
  localparam logic [1:0] LANES_ONE = 2'h0;            // lane width codes
  localparam logic [1:0] LANES_TWO = 2'h1;
  localparam logic [1:0] LANES_FOUR = 2'h2;
  localparam logic [5:0] SYNC_RESET = 6'h20;          // select idles high
  localparam logic CONT_RESET = 1'b0;                 // continuous mode off

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_LATENCY, ST_DATA, ST_IGNORE
  } srmr_state_t;

  // decoded shape of one read command
  typedef struct packed {
    logic legal;
    logic [1:0] addrLanes;
    logic [1:0] dataLanes;
    logic ddr;
    logic hasMode;
  } srmr_cmd_t;

  // drive side of the four io pads
  typedef struct packed {
    logic [3:0] value;
    logic [3:0] enable;
  } srmr_pad_t;

endpackage

// [verification/serial_memory_read_commands_test.sv]
`timescale 1ns/1ps
// ------------------------------------------------
// self-checking bench of the read command interpreter
// ------------------------------------------------
module serial_memory_read_commands_test;
  logic ref_clk = 1'b0; // 250 MHz
  logic reset = 1'b1; // synchronous, active high
  logic dualLaneProtocol = 1'b0;
  logic quadLaneProtocol = 1'b0;
  logic [3:0] latencyCode = 4'h0;
  logic memReadReady = 1'b1;
  logic chipSelectN, serialClock, memReadValid, continuousMode;
  logic [3:0] ioIn;
  srmr_pkg::srmr_pad_t ioDrive;
  logic [srmr_pkg::ADDR_BITS-1:0] memReadAddr;
  logic [7:0] memReadData;
  int numErrors = 0;
  int checks = 0;
  int cycles = 0;
  // extended mode multi-lane table: opcode, address lanes, data lanes, enable
  logic [7:0] xOp [5] = '{8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'hED};
  int xAl [5] = '{1, 2, 1, 4, 4};
  int xDl [5] = '{2, 2, 4, 4, 4};
  logic [3:0] xEn [5] = '{4'h3, 4'h3, 4'hF, 4'hF, 4'hF};

  // array content model
  function automatic logic [7:0] memByte(input logic [srmr_pkg::ADDR_BITS-1:0] a);
    return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]} ^ 8'h3C;
  endfunction
  assign memReadData = memByte(memReadAddr);

  serial_memory_read_commands #(.FIFO_DEPTH(4)) u_dut (.ref_clk(ref_clk), .reset(reset),
    .chipSelectN(chipSelectN), .serialClock(serialClock), .ioIn(ioIn), .ioDrive(ioDrive),
    .dualLaneProtocol(dualLaneProtocol), .quadLaneProtocol(quadLaneProtocol), .latencyCode(latencyCode),
    .memReadValid(memReadValid), .memReadReady(memReadReady), .memReadAddr(memReadAddr),
    .memReadData(memReadData), .continuousMode(continuousMode));
  srmr_host_model u_host (.chipSelectN(chipSelectN), .serialClock(serialClock), .ioIn(ioIn), .ioDrive(ioDrive));

  always #2 ref_clk = ~ref_clk;
  // array stalls at random, cycle ceiling
  always @(posedge ref_clk) begin
    cycles++;
    memReadReady <= ($urandom % 8) != 0;
    if (cycles > 40000) begin
      numErrors++;
      stop_test();
    end
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      numErrors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // protocol change while deselected
  task automatic proto(input logic d, input logic q);
    @(posedge ref_clk);
    dualLaneProtocol <= d;
    quadLaneProtocol <= q;
  endtask
  // one frame, bytes compared with the content model
  task automatic run(input logic [7:0] op, input bit useOp, input logic [23:0] addr, input logic [7:0] mode,
    input bit hasMode, input int cl, input int al, input int dl, input bit ddr, input logic [3:0] lat,
    input int n, input logic [3:0] expEn);
    logic [7:0] got [$];
    logic [3:0] en;
    @(posedge ref_clk);
    latencyCode <= lat;
    @(posedge ref_clk);
    u_host.read(op, useOp, addr, mode, hasMode, cl, al, dl, ddr, int'(lat), n, got, en);
    check(32'(en), 32'(expEn));
    for (int i = 0; i < n; i++) begin
      if (expEn != 4'h0) check(32'(got[i]), 32'(memByte(addr[18:0] + 19'(i))));
    end
  endtask
  // verdict
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, numErrors);
    if (numErrors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(80));
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // plain read over the top, junk in upper address bits
    run(8'h03, 1, 24'hFFFFFE, 8'h00, 0, 1, 1, 1, 0, 4'h0, 4, 4'h2);
    // fast read enters, then leaves continuous mode
    run(8'h0B, 1, 24'($urandom), 8'hA7, 1, 1, 1, 1, 0, 4'($urandom), 2, 4'h2);
    check(32'(continuousMode), 32'h1);
    run(8'h00, 0, 24'($urandom), 8'h5C, 1, 1, 1, 1, 0, 4'($urandom), 2, 4'h2);
    check(32'(continuousMode), 32'h0);
    // extended mode multi-lane reads
    for (int i = 0; i < 5; i++) begin
      run(xOp[i], 1, 24'($urandom), 8'h00, 1, 1, xAl[i], xDl[i], 0, 4'($urandom), 2, xEn[i]);
    end
    // double rate refused outside quad protocol
    run(8'h0D, 1, 24'($urandom), 8'h00, 1, 1, 1, 1, 0, 4'h1, 1, 4'h0);
    // two lane protocol
    proto(1'b1, 1'b0);
    run(8'h03, 1, 24'($urandom), 8'h00, 0, 2, 2, 2, 0, 4'($urandom), 2, 4'h3);
    run(8'h0B, 1, 24'($urandom), 8'h00, 1, 2, 2, 2, 0, 4'($urandom), 2, 4'h3);
    // four lane protocol, single and double rate
    proto(1'b0, 1'b1);
    run(8'h03, 1, 24'($urandom), 8'h00, 0, 4, 4, 4, 0, 4'($urandom), 2, 4'hF);
    run(8'hEB, 1, 24'($urandom), 8'h00, 1, 4, 4, 4, 0, 4'($urandom), 2, 4'hF);
    run(8'h0D, 1, 24'h07FFFF, 8'hA5, 1, 4, 4, 4, 1, 4'(1 + $urandom % 15), 3, 4'hF);
    check(32'(continuousMode), 32'h1);
    run(8'h00, 0, 24'($urandom), 8'h5A, 1, 4, 4, 4, 1, 4'(1 + $urandom % 15), 2, 4'hF);
    check(32'(continuousMode), 32'h0);
    run(8'hED, 1, 24'($urandom), 8'h00, 1, 4, 4, 4, 1, 4'(1 + $urandom % 15), 2, 4'hF);
    // two lane data read not legal in quad protocol
    run(8'h3B, 1, 24'($urandom), 8'h00, 1, 4, 4, 4, 0, 4'h0, 1, 4'h0);
    stop_test();
  end
endmodule

bind serial_memory_read_commands srmr_assertions u_chk (.ref_clk, .reset, .chipSelectN, .serialClock, .ioIn,
  .ioDrive, .dualLaneProtocol, .quadLaneProtocol, .latencyCode, .memReadValid, .memReadReady, .memReadAddr,
  .memReadData, .continuousMode);

// [verification/srmr_assertions.sv]
`timescale 1ns/1ps
// ------------------------------------------------
// port checker of the read command interpreter
// ------------------------------------------------
module srmr_assertions (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic chipSelectN,
  input wire logic serialClock,
  input wire logic [3:0] ioIn,
  input wire srmr_pkg::srmr_pad_t ioDrive,
  input wire logic dualLaneProtocol,
  input wire logic quadLaneProtocol,
  input wire logic [3:0] latencyCode,
  input wire logic memReadValid,
  input wire logic memReadReady,
  input wire logic [srmr_pkg::ADDR_BITS-1:0] memReadAddr,
  input wire logic [7:0] memReadData,
  input wire logic continuousMode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire logic accept = memReadValid && memReadReady; // fetch taken this cycle

  // outputs cleared while reset is applied
  property p_reset_quiet;
    disable iff (1'b0) reset |=> ioDrive == 8'h00 && memReadAddr == 19'h00000 && !continuousMode;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared by reset");
  // lanes released once deselect has been seen
  property p_release;
    chipSelectN [*5] |-> ioDrive.enable == 4'h0;
  endproperty
  a_release: assert property (p_release) else $error("lanes driven while deselected");
  // no array fetch while deselected
  property p_no_fetch;
    chipSelectN [*4] |-> !memReadValid;
  endproperty
  a_no_fetch: assert property (p_no_fetch) else $error("fetch while deselected");
  // next byte address after each taken fetch
  property p_step;
    accept && memReadAddr != 19'h7FFFF |=> memReadAddr == $past(memReadAddr) + 19'h00001;
  endproperty
  a_step: assert property (p_step) else $error("fetch address did not advance");
  // top byte wraps to zero
  property p_wrap;
    accept && memReadAddr == 19'h7FFFF |=> memReadAddr == 19'h00000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("fetch address did not wrap");
  // stalled fetch keeps its address
  property p_hold;
    memReadValid && !memReadReady |=> $stable(memReadAddr);
  endproperty
  a_hold: assert property (p_hold) else $error("fetch address moved while stalled");
  // only one, two or four lane shapes
  property p_lanes;
    ioDrive.enable != 4'h0 |-> ioDrive.enable inside {4'h2, 4'h3, 4'hF};
  endproperty
  a_lanes: assert property (p_lanes) else $error("illegal lane enable");
  // four lane protocol drives all lanes
  property p_quad;
    quadLaneProtocol && ioDrive.enable != 4'h0 |-> ioDrive.enable == 4'hF;
  endproperty
  a_quad: assert property (p_quad) else $error("quad protocol not on four lanes");
  // two lane protocol drives io1 and io0
  property p_dual;
    dualLaneProtocol && !quadLaneProtocol && ioDrive.enable != 4'h0 |-> ioDrive.enable == 4'h3;
  endproperty
  a_dual: assert property (p_dual) else $error("dual protocol not on two lanes");
  // continuous mode kept across deselect
  property p_cont_hold;
    chipSelectN [*6] |=> $stable(continuousMode);
  endproperty
  a_cont_hold: assert property (p_cont_hold) else $error("continuous mode changed while idle");
  // main scenarios reached
  c_wrap: cover property (accept && memReadAddr == 19'h7FFFF);
  c_cont: cover property ($rose(continuousMode));
  c_quad: cover property (ioDrive.enable == 4'hF);
endmodule

// [verification/srmr_host_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------
// host link controller model, clock mode 0
// ------------------------------------------------
module srmr_host_model (
  output logic chipSelectN,
  output logic serialClock,
  output logic [3:0] ioIn,
  input wire srmr_pkg::srmr_pad_t ioDrive
);
  logic [3:0] hostLanes; // host side of the lanes
  // wire level: device drive wins where enabled
  assign ioIn = (ioDrive.value & ioDrive.enable) | (hostLanes & ~ioDrive.enable);
  // idle: deselected, clock parked low
  initial begin
    chipSelectN = 1'b1;
    serialClock = 1'b0;
    hostLanes = 4'h0;
  end
  // one clock step: full cycle single rate, one edge double rate
  task automatic step(input bit ddr);
    if (ddr) begin
      serialClock = ~serialClock;
    end else begin
      serialClock = 1'b1;
      #24 serialClock = 1'b0;
    end
  endtask
  // field out msb first, highest lane first, changed between edges
  task automatic send(input logic [31:0] bits, input int n, input int lanes, input bit ddr);
    for (int k = n - lanes; k >= 0; k -= lanes) begin
      #12 hostLanes = 4'((bits >> k) & ((32'h1 << lanes) - 1));
      #12 step(ddr);
    end
  endtask
  // whole read frame; bytes and last lane enable returned
  task automatic read(input logic [7:0] op, input bit useOp, input logic [23:0] addr, input logic [7:0] mode,
    input bit hasMode, input int cl, input int al, input int dl, input bit ddr, input int lat, input int n,
    output logic [7:0] got [$], output logic [3:0] en);
    logic [7:0] b;
    got = {};
    #1.3 chipSelectN = 1'b0;
    if (useOp) send(32'(op), 8, cl, 1'b0);
    send(32'(addr), 24, al, ddr);
    if (hasMode) send(32'(mode), 8, al, ddr);
    // clock through the dummy cycles
    repeat (lat) begin
      #24;
      step(1'b0);
    end
    for (int i = 0; i < n; i++) begin
      for (int k = 8 - dl; k >= 0; k -= dl) begin
        #12 hostLanes = ~hostLanes;
        #11 b = (b << dl) | 8'((dl == 1) ? 4'(ioIn[1]) : (ioIn & 4'((1 << dl) - 1)));
        en = ioDrive.enable;
        #1 step(ddr);
      end
      got.push_back(b);
    end
    #24 chipSelectN = 1'b1;
    #48;
  endtask
endmodule
